// ---- hw/sbert_defs.svh ----
// Offsets, field positions, reset values and timing counts of the serial BERT block.
// Assumes inclusion by bare name from the package, the sequence register, the top module and the bench.
`ifndef SBERT_DEFS_SVH
`define SBERT_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SBERT_AW 8
`define SBERT_A_CTRL 8'h00
`define SBERT_A_WORD 8'h04
`define SBERT_A_INJ_PER 8'h08
`define SBERT_A_CMD 8'h0c
`define SBERT_A_STATUS 8'h10
`define SBERT_A_ERR_CNT 8'h14
`define SBERT_A_BIT_CNT 8'h18
`define SBERT_A_WIN_ERR 8'h1c
`define SBERT_A_LOSS_THR 8'h20
`define SBERT_A_INT_STAT 8'h24
`define SBERT_A_INT_MASK 8'h28

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SBERT_CTRL_W 12
`define SBERT_C_GEN_EN 0
`define SBERT_C_PAT_WORD 1
`define SBERT_C_INVERT 2
`define SBERT_C_RATE_EN 3
`define SBERT_C_AUTO 4
`define SBERT_C_DLY_LSB 8
`define SBERT_DLY_W 4
`define SBERT_CTRL_RST 12'h011
`define SBERT_WORD_W 16
`define SBERT_WIDX_W 4
`define SBERT_WORD_RST 16'h00ff
`define SBERT_INJ_PER_RST 16'h03e8
`define SBERT_LOSS_THR_RST 16'h0040
`define SBERT_K_INJECT 0
`define SBERT_K_CLR_CNT 1
`define SBERT_K_CLR_HIST 2
`define SBERT_K_RESEARCH 3
`define SBERT_S_LOCKED 0
`define SBERT_S_DEFAULTS 1
`define SBERT_S_HIST_ERR 2
`define SBERT_S_HIST_LOSS 3
`define SBERT_INT_W 3
`define SBERT_I_LOCK 0
`define SBERT_I_LOSS 1
`define SBERT_I_ERR 2

// ----------------------------------------
// Sequence and timing
// ----------------------------------------
`define SBERT_PSEUDO_RANDOM_SEQUENCE_LEN 23
`define SBERT_TAP_A 22
`define SBERT_TAP_B 17
`define SBERT_SEED 23'h7fffff
`define SBERT_LOCK_RUN 6'h20
`define SBERT_WIN_BITS 1024
`define SBERT_PCLK_NS 25
`define SBERT_BIT_NS 200
`define SBERT_BIT_CYC (`SBERT_BIT_NS / `SBERT_PCLK_NS)
`define SBERT_BOOT_LOAD 2'h3

`endif

// ---- hw/sbert_pkg.sv ----
// Types of the serial BERT block: receiver states and the registered state records.
// Assumes sbert_defs.svh is on the include path.
`include "sbert_defs.svh"

package sbert_pkg;

    typedef enum logic [1:0] {SBERT_RX_OFF, SBERT_RX_SEARCH, SBERT_RX_LOCK} sbert_rx_state_t;

    typedef struct packed {
        logic [`SBERT_PSEUDO_RANDOM_SEQUENCE_LEN-1:0] lfsr;
    } sbert_pseudo_random_sequence_state_t;

    typedef struct packed {
        sbert_rx_state_t rxs;
        logic [1:0] boot_cnt;
        logic boot_done;
        logic defaults_loaded;
        logic [`SBERT_CTRL_W-1:0] ctrl;
        logic [`SBERT_WORD_W-1:0] word;
        logic [15:0] inj_period;
        logic [15:0] loss_thr;
        logic [`SBERT_INT_W-1:0] int_stat;
        logic [`SBERT_INT_W-1:0] int_mask;
        logic irq;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic [7:0] tx_div;
        logic tx_clk;
        logic tx_data;
        logic tx_sync;
        logic q4;
        logic tx_div4;
        logic [`SBERT_WIDX_W-1:0] widx_tx;
        logic inj_pend;
        logic [15:0] inj_cnt;
        logic rxc_s1;
        logic rxc_s2;
        logic rxc_s3;
        logic rxd_s1;
        logic rxd_s2;
        logic rst_s1;
        logic rst_s2;
        logic [15:0] dly;
        logic [`SBERT_WIDX_W-1:0] widx_rx;
        logic [5:0] run;
        logic [15:0] win_pos;
        logic [15:0] win_err;
        logic [15:0] win_err_last;
        logic [31:0] err_cnt;
        logic [31:0] bit_cnt;
        logic hist_err;
        logic hist_loss;
        logic locked;
    } sbert_state_t;

endpackage

// ---- hw/sbert_prbs23.sv ----
// Pseudo-random sequence register with feedback x^23 + x^18 + 1.
// Assumes a single clock; load shifts an outside bit in, adv shifts feedback in.
`timescale 1ns/1ps
`default_nettype none
`include "sbert_defs.svh"

module sbert_prbs23 (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic adv,
    input wire logic din,
    output logic [`SBERT_PSEUDO_RANDOM_SEQUENCE_LEN-1:0] state,
    output logic fb
);

    sbert_pkg::sbert_pseudo_random_sequence_state_t s;
    sbert_pkg::sbert_pseudo_random_sequence_state_t n;

    // ----------------------------------------
    // Feedback and shift
    // ----------------------------------------
    assign fb = s.lfsr[`SBERT_TAP_A] ^ s.lfsr[`SBERT_TAP_B];
    assign state = s.lfsr;

    always_comb begin
        n = s;
        if (load) begin
            n.lfsr = {s.lfsr[`SBERT_PSEUDO_RANDOM_SEQUENCE_LEN-2:0], din};
        end else if (adv) begin
            n.lfsr = {s.lfsr[`SBERT_PSEUDO_RANDOM_SEQUENCE_LEN-2:0], fb};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{lfsr: `SBERT_SEED};
        end else begin
            s <= n;
        end
    end

endmodule
`default_nettype wire

// ---- hw/sbert_top.sv ----
// Serial BERT pattern generator and error analyzer with an APB register file.
// Assumes pclk at 40 MHz; rx_clk, rx_data and restore_req are asynchronous pins.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "sbert_defs.svh"

module sbert_top #(
    parameter int BIT_CYC = `SBERT_BIT_CYC,
    parameter int WIN_BITS = `SBERT_WIN_BITS
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SBERT_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [`SBERT_CTRL_W-1:0] retained_cfg,
    input wire logic restore_req,
    output logic tx_clk,
    output logic tx_data,
    output logic tx_clk_div4,
    output logic tx_sync,
    input wire logic rx_clk,
    input wire logic rx_data,
    output logic rx_locked
);

    sbert_pkg::sbert_state_t s;
    sbert_pkg::sbert_state_t n;

    logic [`SBERT_PSEUDO_RANDOM_SEQUENCE_LEN-1:0] tx_state;
    logic tx_fb;
    logic rx_fb;
    logic tx_start;
    logic tx_adv;
    logic rx_rise;
    logic rx_bit;
    logic rx_load;
    logic rx_adv;
    logic gen_en;
    logic pat_word;
    logic inv;
    logic [15:0] rx_line;

    // ----------------------------------------
    // Shared decode
    // ----------------------------------------
    assign gen_en = s.ctrl[`SBERT_C_GEN_EN];
    assign pat_word = s.ctrl[`SBERT_C_PAT_WORD];
    assign inv = s.ctrl[`SBERT_C_INVERT];
    assign tx_start = (s.tx_div == 8'(BIT_CYC - 1));
    assign tx_adv = tx_start & gen_en & ~pat_word;
    assign rx_rise = s.rxc_s2 & ~s.rxc_s3;
    assign rx_line = {s.dly[14:0], s.rxd_s2};
    assign rx_bit = rx_line[s.ctrl[`SBERT_C_DLY_LSB +: `SBERT_DLY_W]] ^ inv;
    assign rx_load = rx_rise & (s.rxs == sbert_pkg::SBERT_RX_SEARCH);
    assign rx_adv = rx_rise & (s.rxs == sbert_pkg::SBERT_RX_LOCK);

    // ----------------------------------------
    // Sequence generators
    // ----------------------------------------
    sbert_prbs23 u_tx_pseudo_random_sequence (
        .clk(pclk),
        .rst_n(presetn),
        .load(1'b0),
        .adv(tx_adv),
        .din(1'b0),
        .state(tx_state),
        .fb(tx_fb)
    );

    sbert_prbs23 u_rx_pseudo_random_sequence (
        .clk(pclk),
        .rst_n(presetn),
        .load(rx_load),
        .adv(rx_adv),
        .din(rx_bit),
        .state(),
        .fb(rx_fb)
    );

    // ----------------------------------------
    // Next state
    // ----------------------------------------
    always_comb begin
        logic acc;
        logic wr;
        logic [31:0] rd;
        logic rd_ok;
        logic [3:0] cmd;
        logic [`SBERT_INT_W-1:0] ev;
        logic [`SBERT_INT_W-1:0] w1c;
        logic pred;
        logic mism;
        logic [15:0] win_sum;
        logic tx_bit;
        logic rate_hit;
        acc = psel & penable & s.pready;
        wr = acc & pwrite;
        rd = 32'h0;
        rd_ok = 1'b1;
        cmd = 4'h0;
        ev = '0;
        w1c = '0;
        pred = 1'b0;
        mism = 1'b0;
        win_sum = 16'h0;
        tx_bit = 1'b0;
        rate_hit = 1'b0;
        n = s;

        // Pin synchronisers and data delay line
        n.rxc_s1 = rx_clk;
        n.rxc_s2 = s.rxc_s1;
        n.rxc_s3 = s.rxc_s2;
        n.rxd_s1 = rx_data;
        n.rxd_s2 = s.rxd_s1;
        n.rst_s1 = restore_req;
        n.rst_s2 = s.rst_s1;
        n.dly = {s.dly[14:0], s.rxd_s2};

        // APB slave: one wait state, answer on the second access cycle
        unique case (paddr)
            `SBERT_A_CTRL: rd = {20'h0, s.ctrl};
            `SBERT_A_WORD: rd = {16'h0, s.word};
            `SBERT_A_INJ_PER: rd = {16'h0, s.inj_period};
            `SBERT_A_CMD: rd = 32'h0;
            `SBERT_A_STATUS: rd = {28'h0, s.hist_loss, s.hist_err, s.defaults_loaded, s.locked};
            `SBERT_A_ERR_CNT: rd = s.err_cnt;
            `SBERT_A_BIT_CNT: rd = s.bit_cnt;
            `SBERT_A_WIN_ERR: rd = {16'h0, s.win_err_last};
            `SBERT_A_LOSS_THR: rd = {16'h0, s.loss_thr};
            `SBERT_A_INT_STAT: rd = {29'h0, s.int_stat};
            `SBERT_A_INT_MASK: rd = {29'h0, s.int_mask};
            default: rd_ok = 1'b0;
        endcase
        n.pready = psel & penable & ~s.pready;
        n.pslverr = psel & penable & ~s.pready & ~rd_ok;
        if (psel && penable && !s.pready) begin
            n.prdata = pwrite ? 32'h0 : rd;
        end
        if (wr && rd_ok) begin
            unique case (paddr)
                `SBERT_A_CTRL: n.ctrl = pwdata[`SBERT_CTRL_W-1:0];
                `SBERT_A_WORD: n.word = pwdata[`SBERT_WORD_W-1:0];
                `SBERT_A_INJ_PER: n.inj_period = pwdata[15:0];
                `SBERT_A_CMD: cmd = pwdata[3:0];
                `SBERT_A_LOSS_THR: n.loss_thr = pwdata[15:0];
                `SBERT_A_INT_STAT: w1c = pwdata[`SBERT_INT_W-1:0];
                `SBERT_A_INT_MASK: n.int_mask = pwdata[`SBERT_INT_W-1:0];
                default: ;
            endcase
        end

        // Power-up settings: restore pin chooses defaults over retained ones
        if (!s.boot_done) begin
            n.boot_cnt = 2'(s.boot_cnt + 2'h1);
            if (s.boot_cnt == `SBERT_BOOT_LOAD) begin
                n.boot_done = 1'b1;
                if (s.rst_s2) begin
                    n.ctrl = `SBERT_CTRL_RST;
                    n.word = `SBERT_WORD_RST;
                    n.inj_period = `SBERT_INJ_PER_RST;
                    n.loss_thr = `SBERT_LOSS_THR_RST;
                    n.defaults_loaded = 1'b1;
                end else begin
                    n.ctrl = retained_cfg;
                end
            end
        end

        // Generator: bit timing, NRZ data, injection, sync, quarter clock
        n.tx_div = tx_start ? 8'h0 : 8'(s.tx_div + 8'h1);
        n.tx_clk = (n.tx_div < 8'(BIT_CYC / 2));
        n.inj_pend = s.inj_pend | cmd[`SBERT_K_INJECT];
        if (tx_start) begin
            rate_hit = s.ctrl[`SBERT_C_RATE_EN] & ~s.inj_pend
                & (s.inj_cnt >= s.inj_period);
            if (!s.ctrl[`SBERT_C_RATE_EN] || rate_hit) begin
                n.inj_cnt = 16'h0;
            end else begin
                n.inj_cnt = 16'(s.inj_cnt + 16'h1);
            end
            tx_bit = (pat_word ? s.word[s.widx_tx] : tx_fb) ^ inv;
            n.tx_data = gen_en & (tx_bit ^ (s.inj_pend | rate_hit));
            n.inj_pend = cmd[`SBERT_K_INJECT];
            n.tx_sync = gen_en & (pat_word ? (s.widx_tx == '0)
                : (tx_state == `SBERT_SEED));
            n.widx_tx = `SBERT_WIDX_W'(s.widx_tx + 1'b1);
            n.q4 = ~s.q4;
            if (s.q4) begin
                n.tx_div4 = ~s.tx_div4;
            end
        end

        // Analyzer: search, lock, error counting
        pred = pat_word ? s.word[s.widx_rx] : rx_fb;
        mism = rx_bit ^ pred;
        win_sum = 16'(s.win_err + {15'h0, mism});
        unique case (s.rxs)
            sbert_pkg::SBERT_RX_OFF: begin
                n.run = 6'h0;
                if (s.ctrl[`SBERT_C_AUTO]) begin
                    n.rxs = sbert_pkg::SBERT_RX_SEARCH;
                end
            end
            sbert_pkg::SBERT_RX_SEARCH: begin
                if (!s.ctrl[`SBERT_C_AUTO]) begin
                    n.rxs = sbert_pkg::SBERT_RX_OFF;
                end else if (rx_rise) begin
                    if (mism) begin
                        n.run = 6'h0;
                    end else begin
                        n.run = 6'(s.run + 6'h1);
                        n.widx_rx = `SBERT_WIDX_W'(s.widx_rx + 1'b1);
                        if (n.run == `SBERT_LOCK_RUN) begin
                            n.rxs = sbert_pkg::SBERT_RX_LOCK;
                            n.win_pos = 16'h0;
                            n.win_err = 16'h0;
                            ev[`SBERT_I_LOCK] = 1'b1;
                        end
                    end
                end
            end
            sbert_pkg::SBERT_RX_LOCK: begin
                if (cmd[`SBERT_K_RESEARCH]) begin
                    n.rxs = sbert_pkg::SBERT_RX_SEARCH;
                    n.run = 6'h0;
                end else if (rx_rise) begin
                    n.widx_rx = `SBERT_WIDX_W'(s.widx_rx + 1'b1);
                    n.bit_cnt = s.bit_cnt + 32'h1;
                    n.err_cnt = s.err_cnt + {31'h0, mism};
                    n.win_err = win_sum;
                    n.win_pos = 16'(s.win_pos + 16'h1);
                    if (mism) begin
                        n.hist_err = 1'b1;
                        ev[`SBERT_I_ERR] = 1'b1;
                    end
                    if (s.win_pos == 16'(WIN_BITS - 1)) begin
                        n.win_err_last = win_sum;
                        n.win_err = 16'h0;
                        n.win_pos = 16'h0;
                    end
                    if (win_sum > s.loss_thr) begin
                        n.rxs = sbert_pkg::SBERT_RX_SEARCH;
                        n.run = 6'h0;
                        n.hist_loss = 1'b1;
                        ev[`SBERT_I_LOSS] = 1'b1;
                    end
                end
            end
        endcase
        n.locked = (n.rxs == sbert_pkg::SBERT_RX_LOCK);

        // Clear commands; history set wins over its clear
        if (cmd[`SBERT_K_CLR_CNT]) begin
            n.err_cnt = 32'h0;
            n.bit_cnt = 32'h0;
            n.win_err = 16'h0;
            n.win_err_last = 16'h0;
            n.win_pos = 16'h0;
        end
        if (cmd[`SBERT_K_CLR_HIST]) begin
            n.hist_err = rx_adv & mism;
            n.hist_loss = ev[`SBERT_I_LOSS];
        end

        // Interrupt status, write one to clear, set wins
        n.int_stat = (s.int_stat & ~w1c) | ev;
        n.irq = |(n.int_stat & n.int_mask);
    end

    // ----------------------------------------
    // State register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
            s.rxs <= sbert_pkg::SBERT_RX_OFF;
            s.ctrl <= `SBERT_CTRL_RST;
            s.word <= `SBERT_WORD_RST;
            s.inj_period <= `SBERT_INJ_PER_RST;
            s.loss_thr <= `SBERT_LOSS_THR_RST;
            s.tx_div <= 8'(BIT_CYC - 1);
        end else begin
            s <= n;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign tx_clk = s.tx_clk;
    assign tx_data = s.tx_data;
    assign tx_clk_div4 = s.tx_div4;
    assign tx_sync = s.tx_sync;
    assign rx_locked = s.locked;

endmodule
`default_nettype wire

// ---- verification/sbert_dut_model.sv ----
// Device under test on the serial link: passes clock and data back.
// Assumes the generator clock is free running; corrupt inverts data while high.
`timescale 1ns/1ps
`default_nettype none
module sbert_dut_model (
    input wire logic clk_in,
    input wire logic data_in,
    input wire logic corrupt,
    output logic clk_out,
    output logic data_out
);
    // One clock and one data line per direction, with wire delay
    assign #3 clk_out = clk_in;
    assign #3 data_out = data_in ^ corrupt;
endmodule
`default_nettype wire

// ---- verification/sbert_top_chk.sv ----
// Concurrent checks on the serial BERT top-level ports.
// Assumes binding to sbert_top; a single pclk domain with async presetn.
`timescale 1ns/1ps
`default_nettype none
module sbert_top_chk #(
    parameter int BIT_CYC = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic tx_clk,
    input wire logic tx_data,
    input wire logic tx_clk_div4,
    input wire logic tx_sync
);
    logic [15:0] cyc_r;
    logic [2:0] rise_r;
    logic seen_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ----------------------------------------
    // Bit clock counters
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_r <= 16'h0000;
            rise_r <= 3'h0;
            seen_r <= 1'b0;
        end else begin
            if ($rose(tx_clk)) begin
                cyc_r <= 16'h0001;
                seen_r <= 1'b1;
            end else begin
                cyc_r <= cyc_r + 16'h0001;
            end
            if ($changed(tx_clk_div4)) begin
                rise_r <= 3'h1;
            end else if ($rose(tx_clk) && rise_r != 3'h0) begin
                rise_r <= rise_r + 3'h1;
            end
        end
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    bit_period_a: assert property ($rose(tx_clk) && seen_r |-> cyc_r == 16'(BIT_CYC))
        else $error("bit clock period wrong");
    mid_fall_a: assert property ($fell(tx_clk) && seen_r |-> cyc_r == 16'(BIT_CYC / 2))
        else $error("bit clock fall not mid-bit");
    nrz_edge_a: assert property ($changed(tx_data) |-> $rose(tx_clk))
        else $error("data changed inside a bit");
    quarter_edge_a: assert property ($changed(tx_clk_div4) |-> $rose(tx_clk))
        else $error("quarter clock off bit start");
    quarter_period_a: assert property ($changed(tx_clk_div4) && rise_r != 3'h0 |-> rise_r == 3'h2)
        else $error("quarter clock level not two bits");
    sync_edge_a: assert property ($changed(tx_sync) |-> $rose(tx_clk))
        else $error("sync pulse off bit boundary");
    one_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("ready not in second access cycle");
    no_early_a: assert property (pready |-> $past(penable) && !$past(pready))
        else $error("ready without one wait cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
endmodule

bind sbert_top sbert_top_chk #(.BIT_CYC(BIT_CYC)) sbert_top_chk_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pready(pready),
    .pslverr(pslverr),
    .tx_clk(tx_clk),
    .tx_data(tx_data),
    .tx_clk_div4(tx_clk_div4),
    .tx_sync(tx_sync)
);
`default_nettype wire

// ---- verification/test_serial_bert_pattern_gen_checker.sv ----
// Self-checking bench of the serial BERT: APB master, loopback link.
// Assumes sbert_defs.svh on the include path; BIT_CYC 8 gives a 200 ns bit.
`timescale 1ns/1ps
`default_nettype none
`include "sbert_defs.svh"
`define CHK(got, exp) \
    begin \
        comparisons++; \
        if ((got) !== (exp)) begin \
            n_fail++; \
            $display("wrong value at %0t: got %h expected %h", $time, got, exp); \
        end \
    end
module test_serial_bert_pattern_gen_checker;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdq;
    logic [11:0] retained_cfg;
    logic restore_req, corrupt, errq;
    logic tx_clk, tx_data, tx_clk_div4, tx_sync, rx_clk, rx_data, rx_locked;
    int n_fail = 0;
    int comparisons = 0;
    sbert_top #(.BIT_CYC(8), .WIN_BITS(64)) sbert_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .irq(irq), .retained_cfg(retained_cfg),
        .restore_req(restore_req), .tx_clk(tx_clk), .tx_data(tx_data),
        .tx_clk_div4(tx_clk_div4), .tx_sync(tx_sync), .rx_clk(rx_clk),
        .rx_data(rx_data), .rx_locked(rx_locked)
    );
    sbert_dut_model sbert_dut_model_inst (
        .clk_in(tx_clk), .data_in(tx_data), .corrupt(corrupt),
        .clk_out(rx_clk), .data_out(rx_data)
    );
    // ----------------------------------------
    // Bus and wait tasks
    // ----------------------------------------
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rdq = prdata;
        errq = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_lock(input logic v);
        int n;
        n = 0;
        while (rx_locked !== v && n < 4000) begin
            @(posedge pclk);
            n++;
        end
    endtask
    task automatic do_reset(input logic rst_restore);
        @(posedge pclk);
        presetn <= 1'b0;
        restore_req <= rst_restore;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        restore_req <= 1'b0;
    endtask
    task automatic end_of_test();
        if (n_fail == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_boot();
        do_reset(1'b1);
        apb(1'b0, `SBERT_A_CTRL, 32'h0);
        `CHK(rdq, 32'(`SBERT_CTRL_RST))
        apb(1'b0, `SBERT_A_WORD, 32'h0);
        `CHK(rdq, 32'(`SBERT_WORD_RST))
        apb(1'b0, `SBERT_A_INJ_PER, 32'h0);
        `CHK(rdq, 32'(`SBERT_INJ_PER_RST))
        apb(1'b0, `SBERT_A_LOSS_THR, 32'h0);
        `CHK(rdq, 32'(`SBERT_LOSS_THR_RST))
        apb(1'b0, `SBERT_A_STATUS, 32'h0);
        `CHK(rdq[1], 1'b1)
        apb(1'b0, 8'h2c, 32'h0);
        `CHK({errq, rdq}, 33'h100000000)
        do_reset(1'b0);
        apb(1'b0, `SBERT_A_CTRL, 32'h0);
        `CHK(rdq, 32'h00000015)
        apb(1'b0, `SBERT_A_STATUS, 32'h0);
        `CHK(rdq[1], 1'b0)
    endtask
    task automatic t_word();
        logic [15:0] w;
        int n;
        w = 16'hc35a;
        apb(1'b1, `SBERT_A_WORD, 32'(w));
        for (int inv = 0; inv < 2; inv++) begin
            apb(1'b1, `SBERT_A_CTRL, 32'h00000013 | 32'(inv << 2));
            n = 0;
            repeat (2) @(negedge tx_clk);
            while (tx_sync !== 1'b1 && n < 40) begin
                @(negedge tx_clk);
                n++;
            end
            for (int i = 0; i < 16; i++) begin
                `CHK(tx_data, w[i] ^ 1'(inv))
                `CHK(tx_sync, 1'(i == 0))
                @(negedge tx_clk);
            end
        end
    endtask
    task automatic t_pseudo_random_sequence();
        logic [63:0] b;
        apb(1'b1, `SBERT_A_INT_STAT, 32'h00000007);
        apb(1'b1, `SBERT_A_CTRL, 32'h00000411);
        apb(1'b1, `SBERT_A_CMD, 32'h00000008);
        @(posedge pclk);
        `CHK(rx_locked, 1'b0)
        repeat (2) @(negedge tx_clk);
        for (int i = 0; i < 64; i++) begin
            b[i] = tx_data;
            @(negedge tx_clk);
        end
        for (int i = 23; i < 64; i++) begin
            `CHK(b[i], b[i-23] ^ b[i-18])
        end
        wait_lock(1'b1);
        `CHK(rx_locked, 1'b1)
        apb(1'b0, `SBERT_A_INT_STAT, 32'h0);
        `CHK(rdq[0], 1'b1)
    endtask
    task automatic t_inject();
        apb(1'b1, `SBERT_A_CMD, 32'h00000002);
        apb(1'b0, `SBERT_A_ERR_CNT, 32'h0);
        `CHK(rdq, 32'h00000000)
        repeat (3) begin
            apb(1'b1, `SBERT_A_CMD, 32'h00000001);
            repeat (5) @(negedge tx_clk);
        end
        apb(1'b0, `SBERT_A_ERR_CNT, 32'h0);
        `CHK(rdq, 32'h00000003)
        apb(1'b0, `SBERT_A_STATUS, 32'h0);
        `CHK(rdq[2], 1'b1)
        `CHK(irq, 1'b0)
        apb(1'b1, `SBERT_A_INT_MASK, 32'h00000004);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b1, `SBERT_A_INT_STAT, 32'h00000007);
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b1, `SBERT_A_CMD, 32'h00000004);
        apb(1'b0, `SBERT_A_STATUS, 32'h0);
        `CHK(rdq[2], 1'b0)
        apb(1'b0, `SBERT_A_ERR_CNT, 32'h0);
        `CHK(rdq, 32'h00000003)
        apb(1'b1, `SBERT_A_CMD, 32'h00000002);
        apb(1'b0, `SBERT_A_ERR_CNT, 32'h0);
        `CHK(rdq, 32'h00000000)
        apb(1'b1, `SBERT_A_INJ_PER, 32'h00000009);
        apb(1'b1, `SBERT_A_CTRL, 32'h00000419);
        repeat (35) @(negedge tx_clk);
        apb(1'b1, `SBERT_A_CTRL, 32'h00000411);
        repeat (5) @(negedge tx_clk);
        apb(1'b0, `SBERT_A_ERR_CNT, 32'h0);
        `CHK(rdq, 32'h00000003)
        repeat (30) @(negedge tx_clk);
        apb(1'b0, `SBERT_A_ERR_CNT, 32'h0);
        `CHK(rdq, 32'h00000003)
    endtask
    task automatic t_loss();
        apb(1'b1, `SBERT_A_LOSS_THR, 32'h00000002);
        corrupt <= 1'b1;
        wait_lock(1'b0);
        `CHK(rx_locked, 1'b0)
        corrupt <= 1'b0;
        apb(1'b0, `SBERT_A_STATUS, 32'h0);
        `CHK(rdq[3], 1'b1)
        apb(1'b0, `SBERT_A_INT_STAT, 32'h0);
        `CHK(rdq[1], 1'b1)
        wait_lock(1'b1);
        `CHK(rx_locked, 1'b1)
    endtask
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        repeat (30000) @(posedge pclk);
        n_fail++;
        end_of_test();
    end
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        retained_cfg = 12'h015;
        restore_req = 1'b1;
        corrupt = 1'b0;
        t_boot();
        t_word();
        t_pseudo_random_sequence();
        t_inject();
        t_loss();
        end_of_test();
    end
endmodule
`default_nettype wire
